// ===== src/cfgl_loader.sv
`default_nettype none
`include "cfgl_defines.svh"

module cfgl_loader #(
    parameter cfgl_pkg::cfgl_addr_t START_ADDR = `CFGL_START_ADDR,
    parameter cfgl_pkg::cfgl_addr_t NUM_WORDS = `CFGL_NUM_WORDS,
    parameter cfgl_pkg::cfgl_cnt_t READ_WAIT = `CFGL_READ_WAIT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_cell_clk,
    input wire logic i_config_request_n,
    input wire logic i_chain_enable_in_n,
    input wire logic [`CFGL_STRAP_W-1:0] i_scheme_select_straps,
    input wire logic i_flash_wait,
    input wire cfgl_pkg::cfgl_word_t i_flash_data,
    output cfgl_pkg::cfgl_word_t o_flash_data,
    output logic o_flash_data_oe_n,
    output cfgl_pkg::cfgl_addr_t o_flash_word_address,
    output logic o_config_clock_out,
    output logic o_flash_reset_n_out,
    output logic o_flash_select_n,
    output logic o_flash_output_enable_n,
    output logic o_flash_addr_valid_n,
    output logic o_flash_write_enable_n,
    output logic o_flash_bus_oe_n,
    input wire logic i_config_complete,
    output logic o_config_complete,
    output logic o_config_complete_oe_n,
    output logic o_config_status_n,
    output logic o_config_status_oe_n,
    output logic o_chain_enable_out_n,
    output logic o_chain_enable_out_oe_n,
    input wire logic i_ceo_user_en,
    input wire logic i_ceo_user_value,
    output logic o_user_wait,
    output logic o_init_start,
    output logic o_user_mode,
    output logic o_cell_we,
    output logic [`CFGL_CELL_AW-1:0] o_cell_addr,
    output cfgl_pkg::cfgl_word_t o_cell_data
);
    import cfgl_pkg::*;

    // ************************************************************
    // reset release and pin synchronisers
    // ************************************************************
    logic rst_n;
    logic rst_c_n;
    logic [`CFGL_STRAP_W+3:0] pins_s;
    logic req_s;
    logic ce_in_s;
    logic cdone_s;
    logic wait_s;
    logic [`CFGL_STRAP_W-1:0] straps_s;
    cfgl_word_t data_s;
    logic ack_tgl_s;
    logic req_tgl_s;
    logic pins_valid;

    cfgl_sync #(.W(1)) u_rst_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_d(1'b1),
        .o_q(rst_n)
    );

    cfgl_sync #(.W(1)) u_rst_cell_sync (
        .i_clk(i_cell_clk),
        .i_rst_n(i_rst_n),
        .i_d(1'b1),
        .o_q(rst_c_n)
    );

    cfgl_sync #(.W(`CFGL_STRAP_W+4)) u_pin_sync (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_d({i_scheme_select_straps, i_flash_wait, i_config_complete,
              i_chain_enable_in_n, i_config_request_n}),
        .o_q(pins_s)
    );

    // high from the first cycle in which the pin copies hold real levels
    cfgl_sync #(.W(1)) u_valid_sync (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_d(1'b1),
        .o_q(pins_valid)
    );

    assign req_s = pins_s[0];
    assign ce_in_s = pins_s[1];
    assign cdone_s = pins_s[2];
    assign wait_s = pins_s[3];
    assign straps_s = pins_s[`CFGL_STRAP_W+3:4];

    cfgl_sync #(.W(`CFGL_DATA_W)) u_data_sync (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_d(i_flash_data),
        .o_q(data_s)
    );

    // ************************************************************
    // loader state
    // ************************************************************
    cfgl_state_t state_r, state_nxt;
    cfgl_cnt_t cnt_r, cnt_nxt;
    cfgl_addr_t addr_r, addr_nxt;
    cfgl_addr_t words_r, words_nxt;
    cfgl_word_t word_r, word_nxt;
    cfgl_scheme_t scheme_r, scheme_nxt;
    logic strap_taken_r, strap_taken_nxt;
    logic req_prev_r, req_prev_nxt;
    logic req_tgl_r, req_tgl_nxt;
    logic ack_tgl_r, ack_tgl_nxt;
    logic config_clock_out_r, config_clock_out_nxt;
    logic frst_n_r, frst_n_nxt;
    logic sel_n_r, sel_n_nxt;
    logic oe_n_r, oe_n_nxt;
    logic avd_n_r, avd_n_nxt;
    logic bus_oe_n_r, bus_oe_n_nxt;
    logic cdone_oe_n_r, cdone_oe_n_nxt;
    logic status_oe_n_r, status_oe_n_nxt;
    logic ceo_n_r, ceo_n_nxt;
    logic ceo_oe_n_r, ceo_oe_n_nxt;
    logic user_wait_r, user_wait_nxt;
    logic init_r, init_nxt;
    logic user_r, user_nxt;
    logic start;
    logic loading;

    cfgl_sync #(.W(1)) u_ack_sync (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_d(ack_tgl_r),
        .o_q(ack_tgl_s)
    );

    // new request edge, enabled chain slot, and master strapping
    assign start = req_s && !req_prev_r && !ce_in_s && strap_taken_r &&
                   (scheme_r == CFGL_SCH_ACTIVE_PAR);
    assign loading = (state_r != CFGL_ST_IDLE) &&
                     (state_r != CFGL_ST_DONE) &&
                     (state_r != CFGL_ST_USER);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        words_nxt = words_r;
        word_nxt = word_r;
        scheme_nxt = scheme_r;
        strap_taken_nxt = strap_taken_r || pins_valid;
        // edge detector stays clear until the straps are taken
        req_prev_nxt = req_s && strap_taken_r;
        req_tgl_nxt = req_tgl_r;
        config_clock_out_nxt = 1'b0;
        frst_n_nxt = frst_n_r;
        sel_n_nxt = sel_n_r;
        oe_n_nxt = oe_n_r;
        avd_n_nxt = avd_n_r;
        bus_oe_n_nxt = bus_oe_n_r;
        cdone_oe_n_nxt = cdone_oe_n_r;
        status_oe_n_nxt = 1'b1;
        ceo_n_nxt = ceo_n_r;
        ceo_oe_n_nxt = ceo_oe_n_r;
        user_wait_nxt = 1'b1;
        init_nxt = init_r;
        user_nxt = user_r;
        if (!strap_taken_r) begin
            scheme_nxt = cfgl_scheme_t'(straps_s);
        end
        // interface clock is the oscillator halved, so at most 20 MHz
        if (loading) begin
            config_clock_out_nxt = !config_clock_out_r;
        end
        unique case (state_r)
            CFGL_ST_IDLE: begin
                bus_oe_n_nxt = 1'b1;
                sel_n_nxt = 1'b1;
                oe_n_nxt = 1'b1;
                avd_n_nxt = 1'b1;
                frst_n_nxt = 1'b1;
                if (start) begin
                    state_nxt = CFGL_ST_FRESET;
                    cnt_nxt = '0;
                    frst_n_nxt = 1'b0;
                    bus_oe_n_nxt = 1'b0;
                    cdone_oe_n_nxt = 1'b0;
                    ceo_n_nxt = 1'b1;
                    ceo_oe_n_nxt = 1'b0;
                    addr_nxt = START_ADDR;
                    words_nxt = '0;
                end
            end
            CFGL_ST_FRESET: begin
                cnt_nxt = cnt_r + 8'h01;
                if (cnt_r == `CFGL_RST_CYC - 8'h01) begin
                    frst_n_nxt = 1'b1;
                    state_nxt = CFGL_ST_ADDR;
                    cnt_nxt = '0;
                    sel_n_nxt = 1'b0;
                    avd_n_nxt = 1'b0;
                end
            end
            CFGL_ST_ADDR: begin
                // address latched by the flash while valid is low
                cnt_nxt = cnt_r + 8'h01;
                if (cnt_r == `CFGL_ADDR_HOLD_CYC - 8'h01) begin
                    avd_n_nxt = 1'b1;
                    oe_n_nxt = 1'b0;
                    state_nxt = CFGL_ST_READ;
                    cnt_nxt = '0;
                end
            end
            CFGL_ST_READ: begin
                // asynchronous read: wait the access time and the sync
                // delay; the flash wait output plays no part here
                cnt_nxt = cnt_r + 8'h01;
                if (cnt_r == READ_WAIT + `CFGL_SYNC_CYC - 8'h01) begin
                    word_nxt = data_s;
                    oe_n_nxt = 1'b1;
                    req_tgl_nxt = !req_tgl_r;
                    state_nxt = CFGL_ST_XFER;
                end
            end
            CFGL_ST_XFER: begin
                // acked once the echo equals the request toggle
                if (ack_tgl_s == req_tgl_r) begin
                    if (words_r == NUM_WORDS - 24'h000001) begin
                        state_nxt = CFGL_ST_DONE;
                        bus_oe_n_nxt = 1'b1;
                        sel_n_nxt = 1'b1;
                        ceo_n_nxt = 1'b0;
                        cdone_oe_n_nxt = 1'b1;
                    end else begin
                        words_nxt = words_r + 24'h000001;
                        addr_nxt = addr_r + 24'h000001;
                        sel_n_nxt = 1'b0;
                        avd_n_nxt = 1'b0;
                        cnt_nxt = '0;
                        state_nxt = CFGL_ST_ADDR;
                    end
                end
            end
            CFGL_ST_DONE: begin
                // other chain members may still hold the done line low
                if (cdone_s) begin
                    init_nxt = 1'b1;
                    user_nxt = 1'b1;
                    state_nxt = CFGL_ST_USER;
                end
            end
            CFGL_ST_USER: begin
                user_wait_nxt = wait_s;
                if (i_ceo_user_en) begin
                    ceo_n_nxt = i_ceo_user_value;
                end
            end
            default: begin
                state_nxt = CFGL_ST_IDLE;
            end
        endcase
        // request low resets the loader and frees the whole bus
        if (!req_s) begin
            state_nxt = CFGL_ST_IDLE;
            bus_oe_n_nxt = 1'b1;
            sel_n_nxt = 1'b1;
            oe_n_nxt = 1'b1;
            avd_n_nxt = 1'b1;
            frst_n_nxt = 1'b1;
            config_clock_out_nxt = 1'b0;
            cdone_oe_n_nxt = 1'b0;
            status_oe_n_nxt = 1'b0;
            ceo_n_nxt = 1'b1;
            ceo_oe_n_nxt = 1'b1;
            init_nxt = 1'b0;
            user_nxt = 1'b0;
            user_wait_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= CFGL_ST_IDLE;
            cnt_r <= '0;
            addr_r <= '0;
            words_r <= '0;
            word_r <= '0;
            scheme_r <= CFGL_SCH_NONE;
            strap_taken_r <= 1'b0;
            req_prev_r <= 1'b0;
            req_tgl_r <= 1'b0;
            config_clock_out_r <= 1'b0;
            frst_n_r <= 1'b1;
            sel_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            avd_n_r <= 1'b1;
            bus_oe_n_r <= 1'b1;
            cdone_oe_n_r <= 1'b0;
            status_oe_n_r <= 1'b0;
            ceo_n_r <= 1'b1;
            ceo_oe_n_r <= 1'b1;
            user_wait_r <= 1'b1;
            init_r <= 1'b0;
            user_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            words_r <= words_nxt;
            word_r <= word_nxt;
            scheme_r <= scheme_nxt;
            strap_taken_r <= strap_taken_nxt;
            req_prev_r <= req_prev_nxt;
            req_tgl_r <= req_tgl_nxt;
            config_clock_out_r <= config_clock_out_nxt;
            frst_n_r <= frst_n_nxt;
            sel_n_r <= sel_n_nxt;
            oe_n_r <= oe_n_nxt;
            avd_n_r <= avd_n_nxt;
            bus_oe_n_r <= bus_oe_n_nxt;
            cdone_oe_n_r <= cdone_oe_n_nxt;
            status_oe_n_r <= status_oe_n_nxt;
            ceo_n_r <= ceo_n_nxt;
            ceo_oe_n_r <= ceo_oe_n_nxt;
            user_wait_r <= user_wait_nxt;
            init_r <= init_nxt;
            user_r <= user_nxt;
        end
    end

    // ************************************************************
    // constant pin drivers: loader never writes the flash
    // ************************************************************
    cfgl_word_t fdata_r;
    logic fdata_oe_n_r;
    logic we_n_r;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            fdata_r <= '0;
            fdata_oe_n_r <= 1'b1;
            we_n_r <= 1'b1;
        end else begin
            fdata_r <= '0;
            fdata_oe_n_r <= 1'b1;
            we_n_r <= 1'b1;
        end
    end

    assign o_flash_data = fdata_r;
    assign o_flash_data_oe_n = fdata_oe_n_r;
    assign o_flash_write_enable_n = we_n_r;
    assign o_flash_word_address = addr_r;
    assign o_config_clock_out = config_clock_out_r;
    assign o_flash_reset_n_out = frst_n_r;
    assign o_flash_select_n = sel_n_r;
    assign o_flash_output_enable_n = oe_n_r;
    assign o_flash_addr_valid_n = avd_n_r;
    assign o_flash_bus_oe_n = bus_oe_n_r;
    assign o_config_complete = 1'b0;
    assign o_config_complete_oe_n = cdone_oe_n_r;
    assign o_config_status_n = 1'b0;
    assign o_config_status_oe_n = status_oe_n_r;
    assign o_chain_enable_out_n = ceo_n_r;
    assign o_chain_enable_out_oe_n = ceo_oe_n_r;
    assign o_user_wait = user_wait_r;
    assign o_init_start = init_r;
    assign o_user_mode = user_r;

    // ************************************************************
    // cell write domain: toggle handshake, word held stable meanwhile
    // ************************************************************
    logic req_seen_r, req_seen_nxt;
    logic cell_we_r, cell_we_nxt;
    logic [`CFGL_CELL_AW-1:0] cell_addr_r, cell_addr_nxt;
    cfgl_word_t cell_data_r, cell_data_nxt;

    cfgl_sync #(.W(1)) u_req_sync (
        .i_clk(i_cell_clk),
        .i_rst_n(rst_c_n),
        .i_d(req_tgl_r),
        .o_q(req_tgl_s)
    );

    always_comb begin
        req_seen_nxt = req_seen_r;
        ack_tgl_nxt = ack_tgl_r;
        cell_we_nxt = 1'b0;
        cell_addr_nxt = cell_addr_r;
        cell_data_nxt = cell_data_r;
        if (req_tgl_s != req_seen_r) begin
            req_seen_nxt = req_tgl_s;
            cell_we_nxt = 1'b1;
            cell_addr_nxt = words_r;
            cell_data_nxt = word_r;
            ack_tgl_nxt = !ack_tgl_r;
        end
    end

    always_ff @(posedge i_cell_clk or negedge rst_c_n) begin
        if (!rst_c_n) begin
            req_seen_r <= 1'b0;
            ack_tgl_r <= 1'b0;
            cell_we_r <= 1'b0;
            cell_addr_r <= '0;
            cell_data_r <= '0;
        end else begin
            req_seen_r <= req_seen_nxt;
            ack_tgl_r <= ack_tgl_nxt;
            cell_we_r <= cell_we_nxt;
            cell_addr_r <= cell_addr_nxt;
            cell_data_r <= cell_data_nxt;
        end
    end

    assign o_cell_we = cell_we_r;
    assign o_cell_addr = cell_addr_r;
    assign o_cell_data = cell_data_r;

endmodule

`default_nettype wire

// ===== src/cfgl_defines.svh
`ifndef CFGL_DEFINES_SVH
`define CFGL_DEFINES_SVH

// ****************************************************************
// widths
// ****************************************************************
`define CFGL_ADDR_W 24
`define CFGL_DATA_W 16
`define CFGL_CNT_W 8
`define CFGL_STRAP_W 2
`define CFGL_CELL_AW 24

// ****************************************************************
// timing
// ****************************************************************
`define CFGL_CLK_PERIOD_NS 25
`define CFGL_OSC_MHZ 40
`define CFGL_CONFIG_CLOCK_OUT_MAX_MHZ 40
`define CFGL_FLASH_RST_NS 100
`define CFGL_RST_CYC \
    8'((`CFGL_FLASH_RST_NS + `CFGL_CLK_PERIOD_NS - 1) / `CFGL_CLK_PERIOD_NS)
`define CFGL_ADDR_HOLD_CYC 8'h02
`define CFGL_SYNC_CYC 8'h02
`define CFGL_READ_WAIT_CYC 8'h04

// ****************************************************************
// load defaults
// ****************************************************************
`define CFGL_START_ADDR 24'h000000
`define CFGL_NUM_WORDS 24'h000400

`endif

// ===== src/cfgl_pkg.sv
`default_nettype none
`include "cfgl_defines.svh"

package cfgl_pkg;

    typedef logic [`CFGL_ADDR_W-1:0] cfgl_addr_t;
    typedef logic [`CFGL_DATA_W-1:0] cfgl_word_t;
    typedef logic [`CFGL_CNT_W-1:0] cfgl_cnt_t;

    typedef enum logic [2:0] {
        CFGL_ST_IDLE = 3'b000,
        CFGL_ST_FRESET = 3'b001,
        CFGL_ST_ADDR = 3'b010,
        CFGL_ST_READ = 3'b011,
        CFGL_ST_XFER = 3'b100,
        CFGL_ST_DONE = 3'b101,
        CFGL_ST_USER = 3'b110
    } cfgl_state_t;

    typedef enum logic [`CFGL_STRAP_W-1:0] {
        CFGL_SCH_NONE = 2'b00,
        CFGL_SCH_ACTIVE_PAR = 2'b01,
        CFGL_SCH_FAST_PASSIVE = 2'b10,
        CFGL_SCH_OTHER = 2'b11
    } cfgl_scheme_t;

endpackage

`default_nettype wire

// ===== src/cfgl_sync.sv
`default_nettype none

// ****************************************************************
// two-flop synchroniser, clears to zero on reset
// ****************************************************************
module cfgl_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= '0;
            o_q <= '0;
        end else begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end

endmodule

`default_nettype wire

// ===== tb/cfgl_flash_model.sv
`default_nettype none
// ****************
// parallel flash, asynchronous single-word reads
// ****************
module cfgl_flash_model (
    input wire logic i_clk,
    input wire logic i_sel_n,
    input wire logic i_oe_n,
    input wire logic i_rst_n,
    input wire logic [23:0] i_addr,
    input wire logic [15:0] i_salt,
    input wire logic [7:0] i_lag,
    output logic [15:0] o_data,
    output logic o_wait
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_data = 16'h0000;
        o_wait = 1'b1;
    end
    // released bus shows the inverse of its last value
    always @(i_sel_n, i_oe_n, i_rst_n, i_addr) begin
        if (!i_sel_n && !i_oe_n && i_rst_n)
            o_data <= #(i_lag) i_addr[15:0] ^ {2{i_addr[23:16]}} ^ i_salt;
        else
            o_data <= ~o_data;
    end
    always @(posedge i_clk) begin
        o_wait <= 1'($urandom_range(0, 1));
    end
endmodule
`default_nettype wire

// ===== tb/cfgl_loader_props.sv
`default_nettype none
// ****************
// port checks of the loader
// ****************
module cfgl_loader_props #(
    parameter cfgl_pkg::cfgl_addr_t START_ADDR = 24'h000000,
    parameter cfgl_pkg::cfgl_cnt_t READ_WAIT = 8'h04
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_cell_clk,
    input wire logic i_config_request_n,
    input wire logic i_chain_enable_in_n,
    input wire cfgl_pkg::cfgl_addr_t o_flash_word_address,
    input wire logic o_config_clock_out,
    input wire logic o_flash_reset_n_out,
    input wire logic o_flash_output_enable_n,
    input wire logic o_flash_addr_valid_n,
    input wire logic o_flash_write_enable_n,
    input wire logic o_flash_data_oe_n,
    input wire logic o_flash_bus_oe_n,
    input wire logic o_config_complete_oe_n,
    input wire logic o_chain_enable_out_n,
    input wire logic o_user_wait,
    input wire logic o_init_start,
    input wire logic o_user_mode,
    input wire logic o_cell_we
);
    timeunit 1ns;
    timeprecision 100ps;
    import cfgl_pkg::*;
    logic [7:0] oe_cnt_r, oe_cnt_nxt;
    logic oe_prev_r, oe_prev_nxt;
    cfgl_addr_t exp_r, exp_nxt;
    // expected next read address, reloaded by every flash reset pulse
    always_comb begin
        oe_cnt_nxt = o_flash_output_enable_n ? 8'h00 : oe_cnt_r + 8'h01;
        oe_prev_nxt = o_flash_output_enable_n;
        exp_nxt = exp_r;
        if (!o_flash_reset_n_out)
            exp_nxt = START_ADDR;
        else if (o_flash_output_enable_n && !oe_prev_r)
            exp_nxt = o_flash_word_address + 24'h000001;
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            oe_cnt_r <= 8'h00;
            oe_prev_r <= 1'b1;
            exp_r <= START_ADDR;
        end else begin
            oe_cnt_r <= oe_cnt_nxt;
            oe_prev_r <= oe_prev_nxt;
            exp_r <= exp_nxt;
        end
    end
    sequence s_avd_fall;
        $fell(o_flash_addr_valid_n);
    endsequence
    sequence s_read;
        !o_flash_addr_valid_n ##1
            (o_flash_addr_valid_n && !o_flash_output_enable_n);
    endsequence
    write_idle_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) o_flash_write_enable_n && o_flash_data_oe_n)
        else $error("flash write or data drive seen");
    bus_float_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        (i_chain_enable_in_n && !i_config_request_n) [*5] |->
        o_flash_bus_oe_n)
        else $error("bus driven while released");
    rst_pulse_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n || !i_config_request_n)
        $fell(o_flash_reset_n_out) |->
        !o_flash_reset_n_out [*4] ##1 o_flash_reset_n_out)
        else $error("flash reset pulse length wrong");
    clk_rate_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        (o_config_clock_out |=> !o_config_clock_out) and
        (!o_flash_bus_oe_n [*2] |-> $changed(o_config_clock_out)))
        else $error("interface clock rate wrong");
    avd_len_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n || !i_config_request_n)
        s_avd_fall |=> s_read)
        else $error("address valid strobe wrong");
    oe_len_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n || !i_config_request_n)
        $rose(o_flash_output_enable_n) |-> oe_cnt_r == READ_WAIT + 8'h02)
        else $error("output enable length wrong");
    addr_seq_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n || !i_config_request_n)
        s_avd_fall |-> o_flash_word_address == exp_r)
        else $error("read address out of order");
    chain_out_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        $fell(o_chain_enable_out_n) |->
        o_flash_bus_oe_n && o_config_complete_oe_n)
        else $error("chain out before bus release");
    init_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        o_init_start |-> o_user_mode && o_config_complete_oe_n)
        else $error("init while done line held");
    user_wait_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) !o_user_mode |-> o_user_wait)
        else $error("wait passed on while loading");
    cell_pulse_a: assert property (@(posedge i_cell_clk)
        disable iff (!i_rst_n) o_cell_we |=> !o_cell_we)
        else $error("cell write pulse too long");
endmodule
bind cfgl_loader cfgl_loader_props #(
    .START_ADDR(START_ADDR),
    .READ_WAIT(READ_WAIT)
) u_props (
    .i_clk, .i_rst_n, .i_cell_clk, .i_config_request_n,
    .i_chain_enable_in_n, .o_flash_word_address, .o_config_clock_out,
    .o_flash_reset_n_out, .o_flash_output_enable_n, .o_flash_addr_valid_n,
    .o_flash_write_enable_n, .o_flash_data_oe_n, .o_flash_bus_oe_n,
    .o_config_complete_oe_n, .o_chain_enable_out_n, .o_user_wait,
    .o_init_start, .o_user_mode, .o_cell_we
);
`default_nettype wire

// ===== tb/cfgl_loader_tb.sv
`default_nettype none
module cfgl_loader_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NW = 6;
    localparam logic [23:0] SA = 24'h7ffffe;
    logic i_clk = 0, i_cell_clk = 0, i_rst_n = 0;
    logic i_config_request_n = 1, i_chain_enable_in_n = 0;
    logic [1:0] i_scheme_select_straps = 2'b01;
    logic i_flash_wait, i_config_complete, hold_low = 1;
    logic i_ceo_user_en = 0, i_ceo_user_value = 0, w;
    logic [15:0] i_flash_data, o_cell_data, salt = 16'h0000;
    logic [23:0] o_flash_word_address, o_cell_addr;
    logic [7:0] lag = 8'h00;
    logic o_flash_data_oe_n, o_config_clock_out, o_flash_reset_n_out;
    logic o_flash_select_n, o_flash_output_enable_n, o_flash_addr_valid_n;
    logic o_flash_write_enable_n, o_flash_bus_oe_n, o_config_complete_oe_n;
    logic o_chain_enable_out_n, o_user_wait, o_init_start, o_user_mode;
    logic o_cell_we, o_config_status_oe_n, o_chain_enable_out_oe_n;
    int err_count = 0, checked = 0, idx = 0;
    always #12.5 i_clk = ~i_clk;
    initial begin
        #7;
        forever #15 i_cell_clk = ~i_cell_clk;
    end
    // open-drain done line with pull-up, another device may hold it
    assign i_config_complete = !(hold_low || !o_config_complete_oe_n);
    cfgl_flash_model u_cfgl_flash_model (
        .i_clk, .i_sel_n(o_flash_select_n | o_flash_bus_oe_n),
        .i_oe_n(o_flash_output_enable_n | o_flash_bus_oe_n),
        .i_rst_n(o_flash_reset_n_out | o_flash_bus_oe_n),
        .i_addr(o_flash_word_address), .i_salt(salt), .i_lag(lag),
        .o_data(i_flash_data), .o_wait(i_flash_wait)
    );
    cfgl_loader #(.START_ADDR(SA), .NUM_WORDS(24'(NW)), .READ_WAIT(8'h04))
    u_cfgl_loader (
        .i_clk, .i_rst_n, .i_cell_clk, .i_config_request_n,
        .i_chain_enable_in_n, .i_scheme_select_straps, .i_flash_wait,
        .i_flash_data, .o_flash_data(), .o_flash_data_oe_n,
        .o_flash_word_address, .o_config_clock_out, .o_flash_reset_n_out,
        .o_flash_select_n, .o_flash_output_enable_n, .o_flash_addr_valid_n,
        .o_flash_write_enable_n, .o_flash_bus_oe_n, .i_config_complete,
        .o_config_complete(), .o_config_complete_oe_n, .o_config_status_n(),
        .o_config_status_oe_n, .o_chain_enable_out_n,
        .o_chain_enable_out_oe_n, .i_ceo_user_en, .i_ceo_user_value,
        .o_user_wait, .o_init_start, .o_user_mode, .o_cell_we, .o_cell_addr,
        .o_cell_data
    );
    function automatic logic [15:0] word(input logic [23:0] a);
        return a[15:0] ^ {2{a[23:16]}} ^ salt;
    endfunction
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_for(ref logic s, input logic v, input int n);
        for (int k = 0; k < n && s !== v; k++)
            @(negedge i_clk);
        if (s !== v) begin
            err_count++;
            summarize;
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    always @(negedge i_cell_clk) begin
        if (o_cell_we === 1'b1) begin
            chk(o_cell_addr, 24'(idx));
            chk({8'h00, o_cell_data}, {8'h00, word(SA + 24'(idx))});
            idx++;
        end
    end
    task automatic full_load;
        wait_for(o_chain_enable_out_n, 1'b0, 3000);
        chk(24'(idx), 24'(NW));
        chk(24'(o_flash_bus_oe_n), 24'h1);
        chk(24'(o_config_complete_oe_n), 24'h1);
    endtask
    initial begin
        salt = 16'($urandom(32'hf519));
        lag = 8'($urandom_range(0, 40));
        cycles(20);
        chk(24'(o_flash_bus_oe_n), 24'h1);
        i_rst_n = 1;
        full_load();
        cycles(20);
        chk(24'(o_init_start), 24'h0);
        hold_low = 0;
        wait_for(o_init_start, 1'b1, 10);
        chk(24'(o_user_mode), 24'h1);
        chk(24'(o_chain_enable_out_oe_n), 24'h0);
        w = i_flash_wait;
        cycles(3);
        chk(24'(o_user_wait), 24'(w));
        i_ceo_user_en = 1;
        i_ceo_user_value = 1'($urandom);
        repeat (2) begin
            cycles(4);
            chk(24'(o_chain_enable_out_n), 24'(i_ceo_user_value));
            i_ceo_user_value = ~i_ceo_user_value;
        end
        i_ceo_user_en = 0;
        i_chain_enable_in_n = 1;
        i_config_request_n = 0;
        cycles(20);
        chk(24'(o_flash_bus_oe_n), 24'h1);
        chk(24'(o_config_status_oe_n), 24'h0);
        i_config_request_n = 1;
        cycles(60);
        chk(24'(o_flash_select_n), 24'h1);
        chk(24'(o_config_status_oe_n), 24'h1);
        idx = 0;
        i_chain_enable_in_n = 0;
        i_config_request_n = 0;
        cycles(2);
        i_config_request_n = 1;
        cycles(45);
        i_config_request_n = 0;
        cycles(20);
        chk(24'(o_flash_bus_oe_n), 24'h1);
        idx = 0;
        i_config_request_n = 1;
        full_load();
        for (int i = 0; i < 3; i++) begin
            i_rst_n = 0;
            i_scheme_select_straps = 2'(i == 0 ? 0 : i + 1);
            cycles(5);
            i_rst_n = 1;
            cycles(60);
            chk(24'(o_flash_bus_oe_n), 24'h1);
        end
        summarize;
    end
endmodule
`default_nettype wire
